// ### common/rfi_regs.svh
// Register offsets, field positions and reset values of the RTC flag,
// interrupt and entry-validity block.
// Assumes a 32-bit AXI4-Lite register bus and byte addressing.
// Function
// RL1: Writing one to clear command clears flag
// RL2: Bits 0..4: ack, alarm, second, time, calendar
// RL3: Enable bit 0 sets update-ack mask bit
// RL4: Enable bits 1..4 set their mask bits
// RL5: Writing one to disable clears mask bit
// RL6: Mask register reads enabled sources, bits 0..4
// RL7: Validity bit 0 flags invalid time entry
// RL8: Validity bit 1 flags invalid calendar entry
// RL9: Validity bit 2 flags invalid time alarm
// RL10: Validity bit 3 flags invalid calendar alarm
// RL11: Event flags set on event, stay set
// RL12: Alarm flag on match; ack on update permit
// RL13: Interrupt high while unmasked flag set
// RL14: Reset zeroes everything; reserved bits read zero
`ifndef RFI_REGS_SVH
`define RFI_REGS_SVH

// Byte offsets of the registers
`define RFI_OFF_EVENT_STATUS 8'h00
`define RFI_OFF_STATUS_CLEAR 8'h04
`define RFI_OFF_IRQ_ENABLE 8'h08
`define RFI_OFF_IRQ_DISABLE 8'h0c
`define RFI_OFF_IRQ_MASK 8'h10
`define RFI_OFF_ENTRY_VALID 8'h14

// Field layout shared by status, clear, enable, disable and mask
`define RFI_SRC_W 5
`define RFI_BIT_UPDATE_ACK 0
`define RFI_BIT_ALARM 1
`define RFI_BIT_SECOND 2
`define RFI_BIT_TIME_EVT 3
`define RFI_BIT_CAL_EVT 4

// Field layout of the validity register
`define RFI_ENTRY_W 4
`define RFI_BIT_TIME_ENTRY 0
`define RFI_BIT_CAL_ENTRY 1
`define RFI_BIT_TALR_ENTRY 2
`define RFI_BIT_CALR_ENTRY 3

// Reset values
`define RFI_RST_SRC 5'h00
`define RFI_RST_ENTRY 4'h0
`define RFI_RST_WORD 32'h0000_0000

// AXI response codes
`define RFI_RESP_OKAY 2'h0
`define RFI_RESP_SLVERR 2'h2

`endif

// ### common/rfi_pkg.sv
// Types shared by the RTC flag and interrupt block.
// Assumes rfi_regs.svh is compiled before it.
`include "rfi_regs.svh"
package rfi_pkg;
    // One bit for each event source
    typedef logic [`RFI_SRC_W-1:0] rfi_src_type;
    // One bit for each checked entry register
    typedef logic [`RFI_ENTRY_W-1:0] rfi_entry_type;
endpackage

// ### common/rfi_flag_if.sv
// Carrier between the top and its sticky flag bank.
// Assumes one clock domain; the owner holds the flags.
`timescale 1ns/1ps
interface rfi_flag_if;
    // Set pulses, one per source
    rfi_pkg::rfi_src_type set;
    // Clear pulses, one per source
    rfi_pkg::rfi_src_type clr;
    // Current sticky flags
    rfi_pkg::rfi_src_type flags;
    // Flag bank side
    modport owner (input set, input clr, output flags);
    // Controller side
    modport user (output set, output clr, input flags);
endinterface

// ### design/rfi_sticky.sv
// Bank of sticky event flags, set by hardware, cleared by command.
// Assumes set and clear arrive as one-cycle pulses on i_clk.
`timescale 1ns/1ps
`include "rfi_regs.svh"
module rfi_sticky
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Flag carrier
    rfi_flag_if.owner fl
);
    // Flag storage
    rfi_pkg::rfi_src_type flags_q;
    rfi_pkg::rfi_src_type flags_d;

    // Next value: set beats clear, so an event in the clear cycle stays
    always_comb
    begin
        flags_d = (flags_q & ~fl.clr) | fl.set; // RL1 RL11 RL12
    end

    // Flags zero after reset
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            flags_q <= `RFI_RST_SRC; // RL14
        else
            flags_q <= flags_d;
    end

    assign fl.flags = flags_q;
endmodule

// ### design/rfi_entry_check.sv
// Tracks whether each entry register holds invalid data since it was
// last programmed. Assumes the calendar logic pulses i_prog when a
// register is written and qualifies it with the range check in i_bad.
`timescale 1ns/1ps
`include "rfi_regs.svh"
module rfi_entry_check
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Programming strobes and range check results
    input wire rfi_pkg::rfi_entry_type i_prog,
    input wire rfi_pkg::rfi_entry_type i_bad,
    // Invalid flags
    output rfi_pkg::rfi_entry_type o_invalid
);
    // Invalid flag storage
    rfi_pkg::rfi_entry_type invalid_q;

    // Each write reloads its bit from the check; others hold
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            invalid_q <= `RFI_RST_ENTRY; // RL14
        else
            invalid_q <= (invalid_q & ~i_prog) | (i_prog & i_bad); // RL7 RL8 RL9 RL10
    end

    assign o_invalid = invalid_q;
endmodule

// ### design/rfi_top.sv
// Top of the RTC flag, interrupt mask and entry-validity block, with
// its AXI4-Lite register slave.
// Assumes the event and entry inputs come from calendar logic on i_clk,
// so they pass no synchroniser; ADDR_W is at least 8 bits.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Offsets, field positions and reset values
`include "rfi_regs.svh"
module rfi_top
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // AXI4-Lite write address channel
    input wire logic i_awvalid,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    output logic o_awready,
    // AXI4-Lite write data channel
    input wire logic i_wvalid,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    // AXI4-Lite write response channel
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    // AXI4-Lite read address channel
    input wire logic i_arvalid,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_arready,
    // AXI4-Lite read data channel
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // Event pulses from the calendar logic
    input wire logic i_update_ack_evt,
    input wire logic i_alarm_evt,
    input wire logic i_second_evt,
    input wire logic i_time_evt,
    input wire logic i_cal_evt,
    // Entry programming strobes and range check results
    input wire rfi_pkg::rfi_entry_type i_entry_prog,
    input wire rfi_pkg::rfi_entry_type i_entry_bad,
    // Interrupt request, level
    output logic o_irq
);
    // Offset match on the low address byte; used by both read and write
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    // Place a source-wide field in the low bits of a bus word
    function automatic logic [31:0] src_word(input rfi_pkg::rfi_src_type v);
        src_word = {{(32-`RFI_SRC_W){1'b0}}, v};
    endfunction

    // Write channel holding state
    logic awready_q;
    logic wready_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read channel state
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // Interrupt mask and output register
    rfi_pkg::rfi_src_type mask_q;
    logic irq_q;
    // Write side decode
    logic wr_fire;
    logic wr_low_byte;
    logic wr_mapped;
    rfi_pkg::rfi_src_type clear_cmd;
    rfi_pkg::rfi_src_type enable_cmd;
    rfi_pkg::rfi_src_type disable_cmd;
    // Read side decode
    logic rd_fire;
    logic [7:0] raddr;
    logic [31:0] rd_word;
    logic rd_mapped;
    // Gathered events and validity flags
    rfi_pkg::rfi_src_type events;
    rfi_pkg::rfi_entry_type entry_invalid;
    // Protection bits carry no meaning here
    logic unused_prot;

    assign unused_prot = ^{i_awprot, i_arprot};

    // Carrier to the sticky status bank
    rfi_flag_if status_if();

    // Sticky status bank
    rfi_sticky u_status
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .fl(status_if)
    );

    // Entry validity tracker
    rfi_entry_check u_entry
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_prog(i_entry_prog),
        .i_bad(i_entry_bad),
        .o_invalid(entry_invalid)
    );

    // Event inputs placed by bit position
    always_comb
    begin
        events = `RFI_RST_SRC;
        events[`RFI_BIT_UPDATE_ACK] = i_update_ack_evt; // RL2 RL12
        events[`RFI_BIT_ALARM] = i_alarm_evt; // RL12
        events[`RFI_BIT_SECOND] = i_second_evt; // RL11
        events[`RFI_BIT_TIME_EVT] = i_time_evt; // RL11
        events[`RFI_BIT_CAL_EVT] = i_cal_evt; // RL11
    end

    // A write is done once both address and data are held
    assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    // Only byte lane 0 carries command bits
    assign wr_low_byte = wstrb_q[0];

    // Write decode into one-cycle command pulses
    always_comb
    begin
        // No command unless a write completes this cycle
        clear_cmd = `RFI_RST_SRC;
        enable_cmd = `RFI_RST_SRC;
        disable_cmd = `RFI_RST_SRC;
        wr_mapped = 1'b0;
        if (addr_hit(waddr_q, `RFI_OFF_STATUS_CLEAR))
        begin
            wr_mapped = 1'b1;
            // Ones clear, zeros leave the flag alone
            if (wr_fire && wr_low_byte)
                clear_cmd = wdata_q[`RFI_SRC_W-1:0]; // RL1 RL2
        end
        else if (addr_hit(waddr_q, `RFI_OFF_EVENT_STATUS))
        begin
            wr_mapped = 1'b1;
            // Writing one to a status bit also clears it
            if (wr_fire && wr_low_byte)
                clear_cmd = wdata_q[`RFI_SRC_W-1:0]; // RL1
        end
        else if (addr_hit(waddr_q, `RFI_OFF_IRQ_ENABLE))
        begin
            wr_mapped = 1'b1;
            if (wr_fire && wr_low_byte)
                enable_cmd = wdata_q[`RFI_SRC_W-1:0]; // RL3 RL4
        end
        else if (addr_hit(waddr_q, `RFI_OFF_IRQ_DISABLE))
        begin
            wr_mapped = 1'b1;
            if (wr_fire && wr_low_byte)
                disable_cmd = wdata_q[`RFI_SRC_W-1:0]; // RL5
        end
        else if (addr_hit(waddr_q, `RFI_OFF_IRQ_MASK) ||
                 addr_hit(waddr_q, `RFI_OFF_ENTRY_VALID))
        begin
            // Read-only registers accept and ignore writes
            wr_mapped = 1'b1;
        end
        else
        begin
            // Unmapped offset, answered with an error
            wr_mapped = 1'b0;
        end
    end

    // Drive the sticky bank: hardware sets, software clears
    assign status_if.set = events;
    assign status_if.clr = clear_cmd;

    // Write address channel: hold one address until its response
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            aw_have_q <= 1'b0;
            waddr_q <= 8'h00;
        end
        else if (i_awvalid && awready_q)
        begin
            aw_have_q <= 1'b1;
            waddr_q <= i_awaddr[7:0];
        end
        else if (wr_fire)
        begin
            aw_have_q <= 1'b0;
        end
    end

    // Write data channel: hold one word until its response
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            w_have_q <= 1'b0;
            wdata_q <= `RFI_RST_WORD;
            wstrb_q <= 4'h0;
        end
        else if (i_wvalid && wready_q)
        begin
            w_have_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
        end
        else if (wr_fire)
        begin
            w_have_q <= 1'b0;
        end
    end

    // Ready drops after a take so a second beat cannot slip in
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else
        begin
            awready_q <= ~aw_have_q & ~(i_awvalid & awready_q) & ~bvalid_q & ~wr_fire;
            wready_q <= ~w_have_q & ~(i_wvalid & wready_q) & ~bvalid_q & ~wr_fire;
        end
    end

    // Write response follows both halves, held until bready
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `RFI_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? `RFI_RESP_OKAY : `RFI_RESP_SLVERR;
        end
        else if (bvalid_q && i_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Mask: enable sets, disable clears; they never meet in one cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            mask_q <= `RFI_RST_SRC; // RL14
        else
            mask_q <= (mask_q & ~disable_cmd) | enable_cmd; // RL3 RL4 RL5
    end

    // Interrupt is registered, so it trails the flag by one cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            irq_q <= 1'b0; // RL14
        else
            irq_q <= |(status_if.flags & mask_q); // RL13
    end

    // Read request taken when no answer is pending
    assign rd_fire = i_arvalid & arready_q;
    assign raddr = i_araddr[7:0];

    // Read decode; write-only registers read as zero
    always_comb
    begin
        // Mapped and zero unless decoded below
        rd_word = `RFI_RST_WORD;
        rd_mapped = 1'b1;
        if (addr_hit(raddr, `RFI_OFF_EVENT_STATUS))
            rd_word = src_word(status_if.flags); // RL11 RL12
        else if (addr_hit(raddr, `RFI_OFF_IRQ_MASK))
            rd_word = src_word(mask_q); // RL6 RL14
        else if (addr_hit(raddr, `RFI_OFF_ENTRY_VALID))
            rd_word = {{(32-`RFI_ENTRY_W){1'b0}}, entry_invalid}; // RL7 RL8 RL9 RL10
        else if (addr_hit(raddr, `RFI_OFF_STATUS_CLEAR) ||
                 addr_hit(raddr, `RFI_OFF_IRQ_ENABLE) ||
                 addr_hit(raddr, `RFI_OFF_IRQ_DISABLE))
            rd_word = `RFI_RST_WORD; // RL1 RL5
        else
            // Unmapped offset: error response, data zero
            rd_mapped = 1'b0;
    end

    // Read address ready: one read at a time
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            arready_q <= 1'b0;
        else
            arready_q <= ~rvalid_q & ~rd_fire;
    end

    // Read data captured at the take, held until rready
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= `RFI_RST_WORD;
            rresp_q <= `RFI_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? `RFI_RESP_OKAY : `RFI_RESP_SLVERR;
        end
        else if (rvalid_q && i_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_irq = irq_q;
endmodule

// ### tb/rfi_chk.sv
// Checker of the flag, mask and interrupt block, bound to rfi_top.
// Assumes one clock and the handshake timing of the top.
`timescale 1ns/1ps
module rfi_chk
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register bus
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic i_rready,
    input wire logic o_awready,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    // Events and interrupt
    input wire logic i_update_ack_evt,
    input wire logic i_alarm_evt,
    input wire logic i_second_evt,
    input wire logic i_time_evt,
    input wire logic i_cal_evt,
    input wire logic o_irq
);
    // Any event source high
    logic any_evt;
    assign any_evt = i_update_ack_evt | i_alarm_evt | i_second_evt | i_time_evt | i_cal_evt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Read request taken, then answered
    sequence s_take; i_arvalid && o_arready; endsequence
    sequence s_answer; o_rvalid && !o_arready; endsequence
    property p_rd_answer; s_take |=> s_answer; endproperty
    property p_rd_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    property p_wr_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
    property p_wr_busy; o_bvalid |-> !o_awready && !o_wready; endproperty
    property p_rsv_zero; o_rvalid |-> o_rdata[31:5] == 27'h0; endproperty
    property p_rst_quiet; $rose(i_rst_b) |-> !o_irq && !o_rvalid && !o_bvalid; endproperty
    // Interrupt moves only after an event or a register write
    property p_irq_rise; $rose(o_irq) |-> $past(any_evt, 2) || $past(o_bvalid); endproperty
    property p_irq_fall; $fell(o_irq) |-> $past(o_bvalid); endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    a_wr_busy: assert property (p_wr_busy) else $error("ready during response");
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs after reset");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose unprompted");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell unprompted");
endmodule
bind rfi_top rfi_chk chk_u (.i_clk, .i_rst_b, .i_arvalid, .o_arready, .o_rvalid, .o_rdata,
    .i_rready, .o_awready, .o_wready, .o_bvalid, .i_bready, .i_update_ack_evt,
    .i_alarm_evt, .i_second_evt, .i_time_evt, .i_cal_evt, .o_irq);

// ### tb/rfi_tb.sv
// Self-checking bench of the flag, mask and validity block.
// Assumes the register map and latencies of the top.
`timescale 1ns/1ps
`include "rfi_regs.svh"
module testbench;
    // Clock, reset and bus master
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    // Calendar side stimulus
    rfi_pkg::rfi_src_type evt = 5'h00;
    rfi_pkg::rfi_entry_type prog = 4'h0, bad = 4'h0;
    // Design outputs
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int error_cnt = 0;
    int cmp_count = 0;
    // Cycles the master waits before raising bready or rready
    int hold = 0;
    always #25 i_clk = ~i_clk;
    rfi_top #(.ADDR_W(8)) dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(awvalid),
        .i_awaddr(awaddr), .i_awprot(3'h0), .o_awready(awready), .i_wvalid(wvalid),
        .i_wdata(wdata), .i_wstrb(wstrb), .o_wready(wready), .o_bvalid(bvalid),
        .o_bresp(bresp), .i_bready(bready), .i_arvalid(arvalid), .i_araddr(araddr),
        .i_arprot(3'h0), .o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata),
        .o_rresp(rresp), .i_rready(rready), .i_update_ack_evt(evt[0]),
        .i_alarm_evt(evt[1]), .i_second_evt(evt[2]), .i_time_evt(evt[3]),
        .i_cal_evt(evt[4]), .i_entry_prog(prog), .i_entry_bad(bad), .o_irq(irq));
    // Verdict and end of run
    task results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Word comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Write; both channels offered together, released when taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge i_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= (hold == 0);
        for (n = 0; n < 40; n++)
        begin
            @(posedge i_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (n + 1 >= hold) bready <= 1'b1;
        end
        bready <= 1'b0;
        if (n == 40) error_cnt++;
        if (n == 40) results();
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    // Read and compare data and response
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge i_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= (hold == 0);
        for (n = 0; n < 40; n++)
        begin
            @(posedge i_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (n + 1 >= hold) rready <= 1'b1;
        end
        rready <= 1'b0;
        if (n == 40) error_cnt++;
        if (n == 40) results();
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // One-cycle event pulse
    task pulse(input rfi_pkg::rfi_src_type v);
        @(posedge i_clk);
        evt <= v;
        @(posedge i_clk);
        evt <= 5'h00;
    endtask
    // Interrupt settles one edge after the flag or mask
    task irq_is(input logic e);
        @(posedge i_clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // Every place reads zero after reset
    task t_reset();
        for (int a = 0; a < 24; a += 4)
            rd(8'(a), 32'h0, `RFI_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Unmapped place refuses; mask place ignores writes; late ready holds answers
    task t_map();
        wr(8'h18, 32'h1f, `RFI_RESP_SLVERR);
        rd(8'h18, 32'h0, `RFI_RESP_SLVERR);
        hold = 3;
        wr(`RFI_OFF_IRQ_MASK, 32'h1f, `RFI_RESP_OKAY);
        rd(`RFI_OFF_IRQ_MASK, 32'h0, `RFI_RESP_OKAY);
        hold = 0;
    endtask
    // Mask bits set one at a time, zeros change nothing, then cleared
    task t_mask();
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 5; i++)
        begin
            m[i] = 1'b1;
            wr(`RFI_OFF_IRQ_ENABLE, 32'h1 << i, `RFI_RESP_OKAY);
            rd(`RFI_OFF_IRQ_MASK, m, `RFI_RESP_OKAY);
        end
        wr(`RFI_OFF_IRQ_DISABLE, 32'hffff_ffe0, `RFI_RESP_OKAY);
        rd(`RFI_OFF_IRQ_MASK, m, `RFI_RESP_OKAY);
        for (int i = 4; i >= 0; i--)
        begin
            m[i] = 1'b0;
            wr(`RFI_OFF_IRQ_DISABLE, 32'h1 << i, `RFI_RESP_OKAY);
            rd(`RFI_OFF_IRQ_MASK, m, `RFI_RESP_OKAY);
        end
        wr(`RFI_OFF_IRQ_ENABLE, 32'h0, `RFI_RESP_OKAY);
        rd(`RFI_OFF_IRQ_MASK, 32'h0, `RFI_RESP_OKAY);
    endtask
    // Each flag sticks, drives irq when unmasked, clears on a one
    task t_flags();
        for (int i = 0; i < 5; i++)
        begin
            pulse(5'(1 << i));
            rd(`RFI_OFF_EVENT_STATUS, 32'h1 << i, `RFI_RESP_OKAY);
            irq_is(1'b0);
            wr(`RFI_OFF_IRQ_ENABLE, 32'h1 << i, `RFI_RESP_OKAY);
            irq_is(1'b1);
            wr(`RFI_OFF_STATUS_CLEAR, ~(32'h1 << i), `RFI_RESP_OKAY);
            rd(`RFI_OFF_EVENT_STATUS, 32'h1 << i, `RFI_RESP_OKAY);
            wr(`RFI_OFF_IRQ_DISABLE, 32'h1 << i, `RFI_RESP_OKAY);
            irq_is(1'b0);
            wr(`RFI_OFF_STATUS_CLEAR, 32'h1 << i, `RFI_RESP_OKAY);
            rd(`RFI_OFF_EVENT_STATUS, 32'h0, `RFI_RESP_OKAY);
        end
        wr(`RFI_OFF_IRQ_ENABLE, 32'h1f, `RFI_RESP_OKAY);
        pulse(5'h1f);
        irq_is(1'b1);
        wr(`RFI_OFF_STATUS_CLEAR, 32'h1f, `RFI_RESP_OKAY);
        irq_is(1'b0);
    endtask
    // Lane 0 off ignores a clear; status place clears too; set beats clear
    task t_clear();
        pulse(5'h08);
        wstrb <= 4'he;
        wr(`RFI_OFF_STATUS_CLEAR, 32'h08, `RFI_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`RFI_OFF_EVENT_STATUS, 32'h08, `RFI_RESP_OKAY);
        wr(`RFI_OFF_EVENT_STATUS, 32'h08, `RFI_RESP_OKAY);
        rd(`RFI_OFF_EVENT_STATUS, 32'h0, `RFI_RESP_OKAY);
        fork
            wr(`RFI_OFF_STATUS_CLEAR, 32'h02, `RFI_RESP_OKAY);
            begin
                // Event lands on the very edge that applies the clear
                repeat (2) @(posedge i_clk);
                evt <= 5'h02;
                @(posedge i_clk);
                evt <= 5'h00;
            end
        join
        rd(`RFI_OFF_EVENT_STATUS, 32'h02, `RFI_RESP_OKAY);
        wr(`RFI_OFF_STATUS_CLEAR, 32'h02, `RFI_RESP_OKAY);
        rd(`RFI_OFF_EVENT_STATUS, 32'h0, `RFI_RESP_OKAY);
    endtask
    // Validity bits load the check result on each programming strobe
    task t_valid();
        logic [31:0] v;
        v = 32'h0;
        for (int j = 0; j < 8; j++)
        begin
            v[j % 4] = (j < 4);
            @(posedge i_clk);
            prog <= 4'(1 << (j % 4));
            bad <= (j < 4) ? 4'hf : 4'h0;
            @(posedge i_clk);
            prog <= 4'h0;
            rd(`RFI_OFF_ENTRY_VALID, v, `RFI_RESP_OKAY);
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk);
        t_reset();
        t_map();
        t_mask();
        t_flags();
        t_clear();
        t_valid();
        results();
    end
endmodule
